// ---- fsip_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsip_core_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic irq_request,
   input wire logic [2:0] irq_vector,
   input wire logic ack_en,
   input wire logic [3:0] ack_delay,
   output logic core_ack,
   output logic taken_stb,
   output logic [2:0] taken_vec
);
   // ----------------------------------------------------------------
   // Core acknowledge, one pulse per offer after a set wait
   // ----------------------------------------------------------------
   logic [3:0] wait_cnt;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         core_ack <= 1'b0;
         taken_stb <= 1'b0;
         taken_vec <= 3'h7;
         wait_cnt <= 4'h0;
      end
      else
      begin
         core_ack <= 1'b0;
         taken_stb <= core_ack;
         // The ack edge also drops the offer, so no second pulse follows
         if (core_ack)
            wait_cnt <= 4'h0;
         else if (irq_request && ack_en && wait_cnt == ack_delay)
         begin
            core_ack <= 1'b1;
            taken_vec <= irq_vector;
         end
         else if (irq_request && ack_en)
            wait_cnt <= wait_cnt + 4'h1;
         else
            wait_cnt <= 4'h0;
      end
   end
endmodule : fsip_core_model
`default_nettype wire

// ---- fsip_irq_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsip_irq_chk
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic core_ack,
   input wire logic irq_request,
   input wire logic [2:0] irq_vector,
   input wire logic idle_mode,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   import fsip_pkg::*;
   // ----------------------------------------------------------------
   // Port relations
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence ack_taken;
      clk_en && irq_request && core_ack;
   endsequence
   sequence wr_taken;
      clk_en && s_axi_awvalid && s_axi_awready ##0 s_axi_wvalid && s_axi_wready;
   endsequence
   vec_legal_a: assert property (irq_request |-> irq_vector <= 3'h4)
      else $error("vector out of range while offered");
   ack_drop_a: assert property (ack_taken |=> !irq_request)
      else $error("offer stayed up after ack");
   idle_wake_a: assert property (ack_taken |=> !idle_mode)
      else $error("idle not left on taken interrupt");
   // Both halves are held one edge after acceptance; the response shows one edge later
   wr_resp_a: assert property (wr_taken |-> ##2 (s_axi_bvalid &&
      (s_axi_bresp == AXI_OKAY || s_axi_bresp == AXI_SLVERR)))
      else $error("write response missing or illegal");
   rd_resp_a: assert property (clk_en && s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
      else $error("read data missing or upper lanes set");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   ar_pulse_a: assert property (clk_en && s_axi_arready |=> !s_axi_arready)
      else $error("arready held past one cycle");
endmodule : fsip_irq_chk
`default_nettype wire

// ---- fsip_irq_unit.sv ----
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fsip_irq_unit
#(
   parameter int ADDR_W = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic ext_irq_pin_0,
   input wire logic ext_irq_pin_1,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic tx_done_flag,
   input wire logic rx_done_flag,
   input wire logic core_ack,
   input wire logic core_reti,
   output logic irq_request,
   output logic [2:0] irq_vector,
   output logic idle_mode,
   output logic irq,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import fsip_pkg::*;

   // ----------------------------------------------------------------
   // Types and functions
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_RUN = 2'b00,
      ST_OFFER = 2'b01
   } fsip_state_t;

   // Level of one source from its two priority bits
   function automatic logic [1:0] fsip_level(input logic hi, input logic lo);
      fsip_level = {hi, lo};
   endfunction : fsip_level

   // Highest active level in a 4-bit level set, or -1 encoded as valid=0
   function automatic logic [2:0] fsip_top_level(input logic [3:0] set);
      fsip_top_level = 3'h0;
      for (int l = 0; l < 4; l++)
      begin
         if (set[l])
         begin
            fsip_top_level = {1'b1, 2'(l)};
         end
      end
   endfunction : fsip_top_level

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] ext_meta;
   logic [1:0] ext_sync;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ext_meta <= 2'h0;
         ext_sync <= 2'h0;
      end
      else if (clk_en)
      begin
         ext_meta <= {ext_irq_pin_1, ext_irq_pin_0};
         ext_sync <= ext_meta;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] interrupt_enable;
   logic [7:0] priority_low_reg;
   logic [7:0] priority_high_reg;
   logic [7:0] power_control_reg;
   logic [NUM_EVENTS-1:0] irq_status;
   logic [NUM_EVENTS-1:0] irq_mask;
   logic [3:0] in_service;
   logic [2:0] active_src;
   fsip_state_t state;

   logic [NUM_SOURCES-1:0] src_flag;
   logic [NUM_SOURCES-1:0] src_pending;
   logic [1:0] src_level [NUM_SOURCES];
   logic [2:0] win_src;
   logic [1:0] win_level;
   logic win_valid;
   logic [2:0] run_top;
   logic preempt_ok;
   logic take;

   // Polling order follows bit order: ext0, timer0, ext1, timer1, serial
   assign src_flag = {tx_done_flag | rx_done_flag, timer1_overflow, ext_sync[1],
                      timer0_overflow, ext_sync[0]};

   always_comb
   begin
      win_src = NO_SOURCE;
      win_level = 2'h0;
      win_valid = 1'b0;
      for (int s = NUM_SOURCES - 1; s >= 0; s--)
      begin
         src_level[s] = fsip_level(priority_high_reg[s], priority_low_reg[s]);
         src_pending[s] = src_flag[s] & interrupt_enable[s]
                          & interrupt_enable[GLOBAL_ENABLE_BIT];
      end
      // Scanning down with >= lets the earliest polled source win a tie
      for (int s = NUM_SOURCES - 1; s >= 0; s--)
      begin
         if (src_pending[s] && (!win_valid || src_level[s] >= win_level))
         begin
            win_src = 3'(s);
            win_level = src_level[s];
            win_valid = 1'b1;
         end
      end
   end

   assign run_top = fsip_top_level(in_service);
   // Level 3 can never satisfy the strict compare, so it runs to completion
   assign preempt_ok = !run_top[2] || (win_level > run_top[1:0]);
   assign take = (state == ST_OFFER) && core_ack;

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic wr_fire;
   logic wr_hit;
   logic [7:0] wbyte;

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wbyte = w_data[7:0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb
   begin
      unique case (aw_addr[7:0])
         ADDR_ENABLE, ADDR_PRIORITY_LOW, ADDR_PRIORITY_HIGH, ADDR_POWER_CONTROL,
         ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_COMPLETE, ADDR_CORE_STATUS,
         ADDR_IN_SERVICE, ADDR_SOURCE_FLAGS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Byte lane 0 carries the whole register; a single-bit update is a byte
   // write with only that bit changed, since AXI has no finer strobe
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         interrupt_enable <= ENABLE_RESET;
         priority_low_reg <= PRIORITY_RESET;
         priority_high_reg <= PRIORITY_RESET;
         irq_mask <= '0;
      end
      else if (clk_en && wr_fire && w_strb[0])
      begin
         unique case (aw_addr[7:0])
            ADDR_ENABLE: interrupt_enable <= wbyte & ENABLE_WRITE_MASK;
            ADDR_PRIORITY_LOW: priority_low_reg <= wbyte & PRIORITY_WRITE_MASK;
            ADDR_PRIORITY_HIGH: priority_high_reg <= wbyte & PRIORITY_WRITE_MASK;
            ADDR_IRQ_MASK: irq_mask <= wbyte[NUM_EVENTS-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Idle mode
   // ----------------------------------------------------------------
   logic idle_set;
   assign idle_set = clk_en && wr_fire && w_strb[0] && (aw_addr[7:0] == ADDR_POWER_CONTROL);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         power_control_reg <= 8'h00;
      end
      else if (clk_en)
      begin
         if (take)
         begin
            power_control_reg[IDLE_BIT] <= 1'b0;
         end
         else if (idle_set)
         begin
            power_control_reg[IDLE_BIT] <= wbyte[IDLE_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Offer to core and nesting
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= ST_RUN;
         irq_request <= 1'b0;
         irq_vector <= NO_SOURCE;
         active_src <= NO_SOURCE;
      end
      else if (clk_en)
      begin
         unique case (state)
            ST_RUN:
            begin
               if (win_valid && preempt_ok)
               begin
                  state <= ST_OFFER;
                  irq_request <= 1'b1;
                  irq_vector <= win_src;
               end
            end
            ST_OFFER:
            begin
               // Withdraw if the request vanished before the core took it
               if (core_ack)
               begin
                  state <= ST_RUN;
                  irq_request <= 1'b0;
                  active_src <= irq_vector;
               end
               else if (!(win_valid && preempt_ok))
               begin
                  state <= ST_RUN;
                  irq_request <= 1'b0;
               end
               else
               begin
                  irq_vector <= win_src;
               end
            end
            default:
            begin
               state <= ST_RUN;
               irq_request <= 1'b0;
            end
         endcase
      end
   end

   // One bit per level; return clears the highest running level
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         in_service <= 4'h0;
      end
      else if (clk_en)
      begin
         logic [3:0] next_in_service;
         next_in_service = in_service;
         if (core_reti && run_top[2])
         begin
            next_in_service[run_top[1:0]] = 1'b0;
         end
         if (take)
         begin
            next_in_service[src_level[irq_vector]] = 1'b1;
         end
         in_service <= next_in_service;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status
   // ----------------------------------------------------------------
   logic [NUM_EVENTS-1:0] evt;
   logic [NUM_EVENTS-1:0] st_clear;
   assign evt[EVT_TAKEN] = take;
   assign evt[EVT_NEST] = take && run_top[2];
   assign evt[EVT_WAKE] = take && power_control_reg[IDLE_BIT];
   assign st_clear = (wr_fire && w_strb[0] && aw_addr[7:0] == ADDR_IRQ_STATUS)
                     ? wbyte[NUM_EVENTS-1:0] : '0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_status <= '0;
         irq <= 1'b0;
         idle_mode <= 1'b0;
      end
      else if (clk_en)
      begin
         // A new event wins over a simultaneous clear
         irq_status <= (irq_status & ~st_clear) | evt;
         irq <= |(((irq_status & ~st_clear) | evt) & irq_mask);
         idle_mode <= take ? 1'b0 : (idle_set ? wbyte[IDLE_BIT] : power_control_reg[IDLE_BIT]);
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   logic [7:0] rd_byte;
   logic rd_hit;

   always_comb
   begin
      rd_hit = 1'b1;
      unique case (s_axi_araddr[7:0])
         ADDR_ENABLE: rd_byte = interrupt_enable;
         ADDR_PRIORITY_LOW: rd_byte = priority_low_reg;
         ADDR_PRIORITY_HIGH: rd_byte = priority_high_reg;
         ADDR_POWER_CONTROL: rd_byte = power_control_reg;
         ADDR_IRQ_STATUS: rd_byte = {5'h00, irq_status};
         ADDR_IRQ_MASK: rd_byte = {5'h00, irq_mask};
         ADDR_CORE_STATUS: rd_byte = {irq_request, 1'b0, 1'b0, win_valid, 1'b0, irq_vector};
         ADDR_IN_SERVICE: rd_byte = {1'b0, active_src, in_service};
         ADDR_SOURCE_FLAGS: rd_byte = {3'h0, src_pending};
         default:
         begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : fsip_irq_unit
`default_nettype wire

// ---- fsip_irq_unit_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
bind fsip_irq_unit fsip_irq_chk i_fsip_irq_chk (.aclk, .aresetn, .clk_en, .core_ack,
   .irq_request, .irq_vector, .idle_mode, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
module fsip_irq_unit_bench;
   import fsip_pkg::*;
   typedef struct {logic [7:0] en; logic [7:0] pl; logic [7:0] ph; logic [5:0] src;
      logic [2:0] vec;} fsip_row_t;
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, core_reti = 1'b0, ack_en = 1'b0;
   logic [3:0] ack_delay = 4'h0, s_axi_wstrb = 4'h0;
   logic [5:0] src = 6'h00;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic core_ack, irq_request, idle_mode, irq, taken_stb, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [2:0] irq_vector, taken_vec;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
   int mismatches = 0, n_tests = 0, cycles = 0;
   // Sources: 0 ext0, 1 timer0, 2 ext1, 3 timer1, 4 tx done, 5 rx done
   fsip_row_t rows [10] = '{
      '{8'h9F, 8'h00, 8'h00, 6'h3F, 3'h0},
      '{8'h9F, 8'h00, 8'h00, 6'h28, 3'h3},
      '{8'h9F, 8'h1F, 8'h10, 6'h3F, 3'h4},
      '{8'h9F, 8'h04, 8'h00, 6'h06, 3'h2},
      '{8'h9F, 8'h02, 8'h01, 6'h03, 3'h0},
      '{8'h9E, 8'h00, 8'h00, 6'h03, 3'h1},
      '{8'h1F, 8'h00, 8'h00, 6'h3F, 3'h7},
      '{8'h9F, 8'h00, 8'h00, 6'h10, 3'h4},
      '{8'h90, 8'h00, 8'h00, 6'h20, 3'h4},
      '{8'h88, 8'h00, 8'h00, 6'h0F, 3'h3}};
   always #5 aclk = ~aclk;
   fsip_irq_unit i_fsip_irq_unit (.aclk, .aresetn, .clk_en, .ext_irq_pin_0(src[0]),
      .ext_irq_pin_1(src[2]), .timer0_overflow(src[1]), .timer1_overflow(src[3]),
      .tx_done_flag(src[4]), .rx_done_flag(src[5]), .core_ack, .core_reti, .irq_request,
      .irq_vector, .idle_mode, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   fsip_core_model i_fsip_core_model (.aclk, .aresetn, .irq_request, .irq_vector, .ack_en,
      .ack_delay, .core_ack, .taken_stb, .taken_vec);
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("counts: %0d compared, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
   endtask : settle
   task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) aw_done = 1'b1;
         if (s_axi_wready === 1'b1) w_done = 1'b1;
         if (aw_done) s_axi_awvalid <= 1'b0;
         if (w_done) s_axi_wvalid <= 1'b0;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      bs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_read
   task automatic take(input logic [2:0] v);
      ack_en <= 1'b1;
      do @(posedge aclk); while (taken_stb !== 1'b1);
      ack_en <= 1'b0;
      check({29'h0, taken_vec}, {29'h0, v});
   endtask : take
   task automatic reti();
      core_reti <= 1'b1;
      @(posedge aclk);
      core_reti <= 1'b0;
      @(posedge aclk);
   endtask : reti
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         wrap_up();
      end
   end
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      settle(5);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (rows[i])
      begin
         axi_read(i == 0 ? ADDR_ENABLE : (i == 1 ? ADDR_PRIORITY_LOW : ADDR_PRIORITY_HIGH));
         if (i < 3) check(rd, 32'h0);
      end
      axi_read(8'h10);
      check({30'h0, rs}, {30'h0, AXI_SLVERR});
      axi_write(8'h10, 8'h00);
      check({30'h0, bs}, {30'h0, AXI_SLVERR});
      axi_write(ADDR_ENABLE, 8'h9F);
      check({30'h0, bs}, {30'h0, AXI_OKAY});
      axi_read(ADDR_ENABLE);
      check(rd, 32'h9F);
      $display("test registers done");
      for (int i = 0; i < 10; i++)
      begin
         ack_delay <= (i % 2 == 1) ? 4'h3 : 4'h0;
         axi_write(ADDR_ENABLE, rows[i].en);
         axi_write(ADDR_PRIORITY_LOW, rows[i].pl);
         axi_write(ADDR_PRIORITY_HIGH, rows[i].ph);
         src <= rows[i].src;
         settle(8);
         check({31'h0, irq_request}, {31'h0, rows[i].vec != NO_SOURCE});
         if (rows[i].vec != NO_SOURCE)
         begin
            check({29'h0, irq_vector}, {29'h0, rows[i].vec});
            take(rows[i].vec);
         end
         src <= 6'h00;
         settle(4);
         if (rows[i].vec != NO_SOURCE) reti();
      end
      $display("test arbitration done");
      axi_write(ADDR_ENABLE, 8'h9F);
      axi_write(ADDR_PRIORITY_LOW, 8'h1B);
      axi_write(ADDR_PRIORITY_HIGH, 8'h1C);
      src <= 6'h02;
      settle(8);
      take(3'h1);
      src <= 6'h01;
      settle(8);
      check({31'h0, irq_request}, 32'h0);
      src <= 6'h05;
      settle(8);
      take(3'h2);
      src <= 6'h15;
      settle(8);
      take(3'h4);
      src <= 6'h1D;
      settle(8);
      check({31'h0, irq_request}, 32'h0);
      src <= 6'h00;
      settle(4);
      repeat (3) reti();
      axi_read(ADDR_IRQ_STATUS);
      check(rd, 32'h3);
      axi_write(ADDR_IRQ_MASK, 8'h01);
      check({31'h0, irq}, 32'h1);
      axi_write(ADDR_IRQ_STATUS, 8'h03);
      check({31'h0, irq}, 32'h0);
      $display("test nesting done");
      axi_write(ADDR_IRQ_MASK, 8'h04);
      axi_write(ADDR_POWER_CONTROL, 8'h01);
      check({31'h0, idle_mode}, 32'h1);
      src <= 6'h02;
      settle(8);
      take(3'h1);
      check({31'h0, idle_mode}, 32'h0);
      settle(2);
      check({31'h0, irq}, 32'h1);
      src <= 6'h00;
      settle(4);
      reti();
      axi_write(ADDR_POWER_CONTROL, 8'h01);
      aresetn <= 1'b0;
      settle(5);
      aresetn <= 1'b1;
      settle(2);
      check({30'h0, idle_mode, irq_request}, 32'h0);
      axi_read(ADDR_ENABLE);
      check(rd, 32'h0);
      $display("test idle and reset done");
      // A frozen unit must not offer a request that appears meanwhile
      axi_write(ADDR_ENABLE, 8'h9F);
      clk_en <= 1'b0;
      src <= 6'h02;
      settle(8);
      check({31'h0, irq_request}, 32'h0);
      clk_en <= 1'b1;
      settle(8);
      check({31'h0, irq_request}, 32'h1);
      axi_read(ADDR_SOURCE_FLAGS);
      check(rd, 32'h2);
      take(3'h1);
      src <= 6'h00;
      settle(4);
      reti();
      $display("test clock enable done");
      wrap_up();
   end
endmodule : fsip_irq_unit_bench
`default_nettype wire

// ---- fsip_pkg.sv ----
package fsip_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_PRIORITY_HIGH = 8'hB7;
   localparam logic [7:0] ADDR_ENABLE = 8'hA8;
   localparam logic [7:0] ADDR_PRIORITY_LOW = 8'hB8;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hC0;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hC4;
   localparam logic [7:0] ADDR_CORE_STATUS = 8'hC8;
   localparam logic [7:0] ADDR_IN_SERVICE = 8'hCC;
   localparam logic [7:0] ADDR_COMPLETE = 8'hD0;
   localparam logic [7:0] ADDR_SOURCE_FLAGS = 8'hD4;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int NUM_SOURCES = 5;
   localparam int GLOBAL_ENABLE_BIT = 7;
   localparam int IDLE_BIT = 0;
   localparam logic [7:0] ENABLE_WRITE_MASK = 8'h9F;
   localparam logic [7:0] PRIORITY_WRITE_MASK = 8'h1F;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] PRIORITY_RESET = 8'h00;
   localparam logic [2:0] NO_SOURCE = 3'h7;
   // Event status bits: 0 taken, 1 preempt, 2 idle wake
   localparam int NUM_EVENTS = 3;
   localparam int EVT_TAKEN = 0;
   localparam int EVT_NEST = 1;
   localparam int EVT_WAKE = 2;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : fsip_pkg
